// ==== eeprom_ctrl.sv ====
// Program/erase control and register front end of a 256-byte nonvolatile array
`timescale 1ns/1ps

module eeprom_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        stop_entry_i,
  input  wire logic        self_check_entry_i,
  input  wire logic        test_mode_req_i,
  output logic             test_mode_grant_o,
  output logic             pump_on_o,
  output logic             bus_clock_output_enable_o,
  output logic             upper_unprotected_o,
  output logic             test_mode_lock_o
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // True when the address falls inside the array window
  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= eeprom_ctrl_pkg::ARRAY_BASE) && (a <= eeprom_ctrl_pkg::ARRAY_LAST);
  endfunction : in_array

  // True when a byte index lies in the region the protect bit guards
  function automatic logic in_upper(input logic [7:0] idx);
    in_upper = (idx >= eeprom_ctrl_pkg::UPPER_FIRST_IDX);
  endfunction : in_upper

  // ****************************************
  // State
  // ****************************************
  logic [7:0] mem [eeprom_ctrl_pkg::ARRAY_DEPTH];
  logic       address_latch_enable;
  logic       erase_select;
  logic       pump_enable;
  logic       bus_clock_output_enable;
  logic       addr_latched;
  logic [7:0] lat_addr;
  logic [7:0] lat_data;
  logic       upper_unprotected;
  logic       test_mode_lock;
  logic       opt_load_pending;
  logic [7:0] rdata;
  logic       test_mode_grant;

  // ****************************************
  // Bus decode
  // ****************************************
  logic       ctrl_wr;
  logic       ctrl_rd;
  logic       arr_wr;
  logic       arr_rd;
  logic [7:0] arr_idx;
  logic [7:0] ctrl_value;
  eeprom_ctrl_pkg::mode_t mode;

  assign arr_wr  = wr_i && in_array(addr_i);
  assign arr_rd  = rd_i && in_array(addr_i);
  assign ctrl_wr = wr_i && (addr_i == eeprom_ctrl_pkg::CTRL_ADDR);
  assign ctrl_rd = rd_i && (addr_i == eeprom_ctrl_pkg::CTRL_ADDR);
  assign arr_idx = addr_i[7:0];

  // Control register image, upper four bits read as zero
  assign ctrl_value = {4'h0,
                       bus_clock_output_enable,
                       erase_select,
                       address_latch_enable,
                       pump_enable};

  // Condition of the array, handy on a waveform
  always_comb
  begin
    if (!address_latch_enable)
      mode = eeprom_ctrl_pkg::MODE_READ;
    else if (pump_enable && erase_select)
      mode = eeprom_ctrl_pkg::MODE_ERASE;
    else if (pump_enable)
      mode = eeprom_ctrl_pkg::MODE_PROGRAM;
    else if (erase_select)
      mode = eeprom_ctrl_pkg::MODE_ERASE_LOAD;
    else
      mode = eeprom_ctrl_pkg::MODE_LOAD;
  end

  // ****************************************
  // Next values of the control bits
  // ****************************************
  logic next_latch;
  logic next_erase;
  logic next_pump;
  logic next_clk_out;
  logic stop_or_keep;

  // stop entry beats a same-cycle control write, except on the clock output bit
  assign stop_or_keep = stop_entry_i;

  // Bus clock output bit is only stored; the pin mux lives outside this block
  assign next_clk_out = ctrl_wr ? wdata_i[eeprom_ctrl_pkg::CLK_OUT_BIT]
                      : bus_clock_output_enable;

  assign next_latch = stop_or_keep ? 1'b0
                    : ctrl_wr      ? wdata_i[eeprom_ctrl_pkg::LATCH_BIT]
                    : address_latch_enable;

  // erase select held low without latch enable
  // once an address is taken the select is frozen
  assign next_erase = !next_latch   ? 1'b0
                    : addr_latched  ? erase_select
                    : ctrl_wr       ? wdata_i[eeprom_ctrl_pkg::ERASE_BIT]
                    : erase_select;

  // A pump write in the same cycle as the latch write is dropped:
  // software must set the latch and take an address first.
  // pump may rise only over a latched address
  // no timeout, it stays up until latch clear
  assign next_pump = !next_latch ? 1'b0
                   : pump_enable ? 1'b1
                   : (ctrl_wr && wdata_i[eeprom_ctrl_pkg::PUMP_BIT]
                      && addr_latched && address_latch_enable);

  // ****************************************
  // Address and data capture
  // ****************************************
  logic capture_ok;
  logic capture;

  // A rewrite of the same address before the pump rises refreshes the
  // data byte; a second address has to wait for a latch clear.
  // capture only with latch set, pump clear
  // a different address is ignored once taken
  assign capture_ok = address_latch_enable && !pump_enable
                   && (!addr_latched || (lat_addr == arr_idx));
  assign capture    = arr_wr && capture_ok && !stop_or_keep;

  // ****************************************
  // Control register process
  // ****************************************

  // reset leaves the register all zero; stop clears every bit but the clock output bit
  // stop also drops the pump, back to read mode
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      address_latch_enable    <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::LATCH_BIT];
      erase_select            <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::ERASE_BIT];
      pump_enable             <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::PUMP_BIT];
      bus_clock_output_enable <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::CLK_OUT_BIT];
    end
    else
    begin
      address_latch_enable    <= next_latch;
      erase_select            <= next_erase;
      pump_enable             <= next_pump;
      bus_clock_output_enable <= next_clk_out;
    end
  end

  // Latched target; forgotten as soon as latch enable drops
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      addr_latched <= 1'b0;
      lat_addr     <= 8'h00;
      lat_data     <= 8'h00;
    end
    else if (!next_latch)
    begin
      addr_latched <= 1'b0;
    end
    else if (capture)
    begin
      addr_latched <= 1'b1;
      lat_addr     <= arr_idx;
      // data kept but unused when erasing
      lat_data     <= wdata_i;
    end
  end

  // ****************************************
  // Array cells
  // ****************************************
  logic op_allowed;
  logic op_active;
  logic op_program;
  logic op_erase;

  // erase select picks which operation the pump drives
  assign op_erase   = (mode == eeprom_ctrl_pkg::MODE_ERASE);
  assign op_program = (mode == eeprom_ctrl_pkg::MODE_PROGRAM);

  // upper bytes need the protect latch set
  assign op_allowed = !in_upper(lat_addr) || upper_unprotected;
  // pump with latch enable starts the operation
  assign op_active  = (op_program || op_erase) && addr_latched;

  // The cells hold no reset: contents survive every reset, as
  // a nonvolatile array must. A fresh simulation sees unknowns
  // until the self-check erase has run once.
  generate
    for (genvar i = 0; i < eeprom_ctrl_pkg::ARRAY_DEPTH; i++)
    begin : g_cell
      always_ff @(posedge clk_i)
      begin
        if (self_check_entry_i)
          mem[i] <= eeprom_ctrl_pkg::ERASED_BYTE;
        // only the one latched byte is touched
        else if (op_active && op_allowed && (lat_addr == 8'(i)))
        begin
          // erase to FF, program only clears bits
          // A byte not erased first keeps its zero bits after programming
          if (op_erase)
            mem[i] <= eeprom_ctrl_pkg::ERASED_BYTE;
          else
            mem[i] <= mem[i] & lat_data;
        end
      end
    end
  endgenerate

  // ****************************************
  // Options latches
  // ****************************************

  // options byte copied in the cycle after reset
  // Held secure and protected while reset is low, the safe side.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      opt_load_pending  <= 1'b1;
      upper_unprotected <= 1'b0;
      test_mode_lock    <= 1'b0;
    end
    else if (opt_load_pending)
    begin
      opt_load_pending  <= 1'b0;
      // A self-check in the load cycle itself must still open the region
      upper_unprotected <= mem[eeprom_ctrl_pkg::OPTIONS_IDX][eeprom_ctrl_pkg::PROTECT_BIT]
                           || self_check_entry_i;
      // the lock latch is only refreshed here
      test_mode_lock    <= mem[eeprom_ctrl_pkg::OPTIONS_IDX][eeprom_ctrl_pkg::LOCK_BIT];
    end
    // erasing the options byte lifts protection to reset
    else if (self_check_entry_i
             || (op_active && erase_select
                 && (lat_addr == eeprom_ctrl_pkg::OPTIONS_IDX)))
    begin
      upper_unprotected <= 1'b1;
    end
  end

  // Grant is held low through the load cycle, so a request cannot
  // slip in on the reset value of the lock latch.
  // test mode granted only with lock bit high
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      test_mode_grant <= 1'b0;
    else
      test_mode_grant <= test_mode_req_i && test_mode_lock && !opt_load_pending;
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] next_rdata;

  // Byte 0x0100 reads the stored options byte, not the working latches;
  // software sees what the next reset will load.
  // latch enable set masks the array with FF
  // an operation in progress never yields cell data
  // latch clear reads the array like ROM
  assign next_rdata = ctrl_rd ? ctrl_value
                    : !arr_rd ? eeprom_ctrl_pkg::UNMAPPED_READ
                    : address_latch_enable ? eeprom_ctrl_pkg::ERASED_BYTE
                    : mem[arr_idx];

  // Driving zero between reads keeps stale cell data off the bus.
  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata <= eeprom_ctrl_pkg::UNMAPPED_READ;
    else if (rd_i)
      rdata <= next_rdata;
    else
      rdata <= eeprom_ctrl_pkg::UNMAPPED_READ;
  end

  // ****************************************
  // Outputs, all straight from flip-flops
  // ****************************************

  // pump output low whenever latch enable is low
  assign pump_on_o                 = pump_enable;
  assign rdata_o                   = rdata;
  assign test_mode_grant_o         = test_mode_grant;
  assign bus_clock_output_enable_o = bus_clock_output_enable;
  assign upper_unprotected_o       = upper_unprotected;
  assign test_mode_lock_o          = test_mode_lock;

  // erase timing left to software by design
  // program timing left to software by design
  // Software holds the pump up for the required time and then
  // drops latch enable; nothing here counts that time.

endmodule : eeprom_ctrl

// ==== eeprom_ctrl_chk.sv ====
// Port-level assertions for the nonvolatile array controller
`timescale 1ns/1ps

module eeprom_ctrl_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        stop_entry_i,
  input wire logic        self_check_entry_i,
  input wire logic        test_mode_req_i,
  input wire logic        test_mode_grant_o,
  input wire logic        pump_on_o,
  input wire logic        bus_clock_output_enable_o,
  input wire logic        upper_unprotected_o,
  input wire logic        test_mode_lock_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Decode of control writes and array hits
  wire logic ctrl_wr = wr_i && addr_i == eeprom_ctrl_pkg::CTRL_ADDR;
  wire logic arr_hit = addr_i[15:8] == 8'h01;
  property p_pump_rise;
    $rose(pump_on_o) |-> $past(ctrl_wr && wdata_i[1:0] == 2'h3);
  endproperty
  a_pump_rise: assert property (p_pump_rise) else $error("pump rose without enable write");
  // latch clear or stop kills pump
  property p_pump_off;
    (stop_entry_i || (ctrl_wr && !wdata_i[1])) |=> !pump_on_o;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump still on");
  property p_busy_read;
    pump_on_o && rd_i && arr_hit |=> rdata_o == eeprom_ctrl_pkg::ERASED_BYTE;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("array read not blocked");
  property p_unmapped;
    rd_i && !arr_hit && addr_i != eeprom_ctrl_pkg::CTRL_ADDR |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_grant;
    test_mode_grant_o == ($past(test_mode_req_i) && $past(test_mode_lock_o));
  endproperty
  a_grant: assert property (p_grant) else $error("test mode grant wrong");
  // lock moves only at reset load
  property p_lock;
    !$stable(test_mode_lock_o) |-> !$past(rst_n_i, 2);
  endproperty
  a_lock: assert property (p_lock) else $error("lock changed outside reset");
  property p_prot_fall;
    $fell(upper_unprotected_o) |-> !$past(rst_n_i);
  endproperty
  a_prot_fall: assert property (p_prot_fall) else $error("protection returned early");
  property p_selfchk;
    rst_n_i && self_check_entry_i |=> upper_unprotected_o;
  endproperty
  a_selfchk: assert property (p_selfchk) else $error("self-check left region guarded");
endmodule : eeprom_ctrl_chk

bind eeprom_ctrl eeprom_ctrl_chk chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .stop_entry_i(stop_entry_i),
  .self_check_entry_i(self_check_entry_i), .test_mode_req_i(test_mode_req_i),
  .test_mode_grant_o(test_mode_grant_o), .pump_on_o(pump_on_o),
  .bus_clock_output_enable_o(bus_clock_output_enable_o),
  .upper_unprotected_o(upper_unprotected_o), .test_mode_lock_o(test_mode_lock_o)
);

// ==== eeprom_ctrl_pkg.sv ====
// Constants for the byte-erasable nonvolatile array controller
package eeprom_ctrl_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [15:0] CTRL_ADDR        = 16'h0007;
  localparam logic [15:0] ARRAY_BASE       = 16'h0100;
  localparam logic [15:0] ARRAY_LAST       = 16'h01ff;
  localparam logic [15:0] OPTIONS_ADDR     = 16'h0100;
  // First byte of the protectable upper region
  localparam logic [7:0]  UPPER_FIRST_IDX  = 8'h20;
  localparam logic [7:0]  OPTIONS_IDX      = 8'h00;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int PUMP_BIT    = 0;
  localparam int LATCH_BIT   = 1;
  localparam int ERASE_BIT   = 2;
  localparam int CLK_OUT_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************
  // Options byte fields
  // ****************************************
  localparam int LOCK_BIT    = 0;
  localparam int PROTECT_BIT = 1;

  // ****************************************
  // Data values
  // ****************************************
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int         ARRAY_DEPTH   = 256;

  // Operating condition of the array, from the three control bits
  typedef enum logic [2:0] {
    MODE_READ       = 3'b000,
    MODE_LOAD       = 3'b001,
    MODE_PROGRAM    = 3'b010,
    MODE_ERASE_LOAD = 3'b011,
    MODE_ERASE      = 3'b100
  } mode_t;

endpackage : eeprom_ctrl_pkg

// ==== testbench.sv ====
// Self-checking bench for the nonvolatile array controller
`timescale 1ns/1ps

module testbench;
  // Row: write flag nibble, address, then write data or expected read data
  typedef logic [27:0] row_t;
  logic        clk_i, rst_n_i, wr_i, rd_i, stop_i, self_chk, req;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  logic        grant, pump, clk_out_en, unprot, lock;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // software erase and program sequences in the rows
  row_t tbl_a[] = '{28'h1000701, 28'h0000700, 28'h1000703, 28'h0000702,
    28'h10105a5, 28'h00105ff, 28'h1000706, 28'h0000702, 28'h1010600, 28'h1000703,
    28'h0000703, 28'h00105ff, 28'h1000700, 28'h0000700, 28'h00105a5, 28'h00106ff,
    28'h1000702, 28'h101ff3c, 28'h1000703, 28'h1000700, 28'h1000702, 28'h101ff0f,
    28'h1000703, 28'h1000700, 28'h001ff0c, 28'h1000706, 28'h1010500, 28'h1000707,
    28'h0000707, 28'h1000700, 28'h00105ff, 28'h001ff0c, 28'h0000000, 28'h1020055,
    28'h0020000, 28'h000ff00, 28'h1000708, 28'h0000708, 28'h1000700, 28'h1000702,
    28'h10100fd, 28'h1000703, 28'h1000700, 28'h00100fd, 28'h1000702};
  // region boundary under protection, then the lock byte
  row_t tbl_b[] = '{28'h1000702, 28'h1012000, 28'h1000703, 28'h1000700,
    28'h00120ff, 28'h1000702, 28'h1011f1e, 28'h1000703, 28'h1000700, 28'h0011f1e,
    28'h1000702, 28'h10100fc, 28'h1000703, 28'h1000700, 28'h00100fc};
  // bytes 0x011f and 0x0100 read blank, then a long program left running
  row_t tbl_c[] = '{28'h0011fff, 28'h00100ff, 28'h1000702, 28'h1012000, 28'h1000703};

  eeprom_ctrl uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata), .stop_entry_i(stop_i), .self_check_entry_i(self_chk),
    .test_mode_req_i(req), .test_mode_grant_o(grant), .pump_on_o(pump),
    .bus_clock_output_enable_o(clk_out_en), .upper_unprotected_o(unprot),
    .test_mode_lock_o(lock)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One strobe cycle; read data looked at only in the cycle after
  task automatic bus(input row_t r);
    @(posedge clk_i);
    wr_i  <= r[24];
    rd_i  <= !r[24];
    addr  <= r[23:8];
    wdata <= r[7:0];
    @(posedge clk_i);
    wr_i <= 1'h0;
    rd_i <= 1'h0;
    if (!r[24])
    begin
      @(negedge clk_i);
      chk(rdata, r[7:0]);
    end
  endtask : bus

  task automatic run(input row_t t[]);
    foreach (t[i]) bus(t[i]);
  endtask : run

  task automatic reset_dut(input int n);
    @(posedge clk_i);
    rst_n_i <= 1'h0;
    repeat (n) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask : reset_dut

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // Clock and hang guard; the whole run is a few hundred cycles
  initial
  begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_mismatch++;
      results();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst_n_i, wr_i, rd_i, stop_i, req, addr, wdata} = '0;
    self_chk = 1'h1;
    // Blank the array in reset so no cell starts unknown
    reset_dut(20);
    @(posedge clk_i);
    self_chk <= 1'h0;
    run(tbl_a);
    $display("done: program and erase table");
    // Bus clock bit set with the latch still up, then cleared by reset
    bus(28'h100070a);
    @(negedge clk_i);
    chk(8'(clk_out_en), 8'h01);
    // Reset lands while latched; options byte reloads
    reset_dut(3);
    chk(8'(clk_out_en), 8'h00);
    chk(8'(pump), 8'h00);
    chk(8'(unprot), 8'h00);
    chk(8'(lock), 8'h01);
    bus(28'h0000700);
    $display("done: reset reload");
    run(tbl_b);
    chk(8'(lock), 8'h01);
    @(posedge clk_i);
    req <= 1'h1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(8'(grant), 8'h01);
    reset_dut(3);
    chk(8'(lock), 8'h00);
    chk(8'(grant), 8'h00);
    $display("done: protect and lock");
    @(posedge clk_i);
    self_chk <= 1'h1;
    @(posedge clk_i);
    self_chk <= 1'h0;
    @(negedge clk_i);
    chk(8'(unprot), 8'h01);
    run(tbl_c);
    // No timeout inside: the pump holds until software or stop
    repeat (40) @(posedge clk_i);
    @(negedge clk_i);
    chk(8'(pump), 8'h01);
    @(posedge clk_i);
    stop_i <= 1'h1;
    @(posedge clk_i);
    stop_i <= 1'h0;
    @(negedge clk_i);
    chk(8'(pump), 8'h00);
    bus(28'h0000700);
    bus(28'h0012000);
    reset_dut(3);
    chk(8'(lock), 8'h01);
    $display("done: self-check and stop");
    results();
  end
endmodule : testbench
